// [rtl/mia_pkg.sv]
package mia_pkg;
  // register port addresses
  localparam logic [15:0] ADDR_REQ_LO = 16'hFFE0;
  localparam logic [15:0] ADDR_REQ_HI = 16'hFFE1;
  localparam logic [15:0] ADDR_MASK_LO = 16'hFFE4;
  localparam logic [15:0] ADDR_MASK_HI = 16'hFFE5;
  localparam logic [15:0] ADDR_STATUS = 16'hFFF0;
  // flag layout: bit i of the 16-bit flag word is source i, lower index wins
  localparam int NUM_SRC = 16;
  localparam logic [15:0] SRC_VALID = 16'h7FFE;
  localparam int SRC_EXT_ZERO = 2;
  localparam int SRC_EXT_ONE = 3;
  localparam int SRC_TIMER_H_ONE = 4;
  // reset values
  localparam logic [15:0] REQ_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'hFFFF;
  localparam logic [7:0] STATUS_RESET = 8'h02;
  localparam int STATUS_IE_BIT = 7;
  // vector table: one 16-bit entry per source, two bytes apart
  localparam logic [15:0] VEC_BASE = 16'h0000;
  // acknowledge timing in cpu clocks
  localparam int ACK_MIN_CLKS = 9;
  localparam int ACK_MAX_CLKS = 19;
  localparam int ACK_FIXED_CLKS = 6;
  localparam logic [3:0] ACK_WAIT_CLKS = 4'(ACK_MIN_CLKS - ACK_FIXED_CLKS);
  // acknowledge sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_PUSH_STATUS = 6'b000010,
    ST_PUSH_PC = 6'b000100,
    ST_WAIT = 6'b001000,
    ST_VEC_FETCH = 6'b010000,
    ST_PC_LOAD = 6'b100000
  } mia_state_t;
endpackage

// [rtl/mia_prio_pick.sv]
`timescale 1ns/1ps
module mia_prio_pick
  import mia_pkg::*;
#(
  parameter int N = NUM_SRC
)(
  input wire logic [N-1:0] reqFlags,
  input wire logic [N-1:0] maskFlags,
  output logic anyEligible,
  output logic [3:0] pickIdx
);
  logic [N-1:0] eligible;

  // per-source eligibility: set request and clear mask
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_elig
      assign eligible[gi] = reqFlags[gi] & ~maskFlags[gi];
    end
  endgenerate

  // fixed priority, lowest index first so ext zero beats ext one beats timer
  always_comb
  begin
    anyEligible = |eligible;
    pickIdx = 4'h0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (eligible[i])
        pickIdx = 4'(i);
    end
  end
endmodule // mia_prio_pick

// [rtl/mia_ack_ctrl.sv]
`timescale 1ns/1ps
// Contract
// - eligible only when flag set, mask clear
// - vectored only while global enable set
// - request to service within 9..19 clocks
// - worst case before bit-test branch instructions
// - simultaneous eligible requests taken by priority
// - pending request taken once conditions allow
// - push status, push pc, clear enable, vector (enable cleared with the status push)
// - flag set before clock n-1 taken after
// - flag set in last clock waits one
// - no acknowledge during flag or mask access
// - defer after flag/mask instruction by one
// - reenabled service may nest any source
// - without reenable, new request waits
// - ext zero over ext one over timer
// - flag set by source, cleared by ack
// - reset sets every mask flag
// - reset loads status word 02H
module mia_ack_ctrl
  import mia_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic [NUM_SRC-1:0] srcReq,
  input wire logic instrEnd,
  input wire logic instrFlagAccess,
  input wire logic eiExec,
  input wire logic diExec,
  input wire logic retiExec,
  input wire logic [7:0] retiStatus,
  input wire logic [15:0] curPc,
  input wire logic [15:0] vecRdData,
  output logic ackBusy,
  output logic stackPushValid,
  output logic [15:0] stackPushData,
  output logic stackPushStatus,
  output logic vecRdValid,
  output logic [15:0] vecRdAddr,
  output logic pcLoadValid,
  output logic [15:0] pcLoadData,
  output logic [7:0] statusWord,
  output logic [3:0] ackSource
);
  typedef struct packed {
    mia_state_t state;
    logic [15:0] reqFlags;
    logic [15:0] maskFlags;
    logic [7:0] status;
    logic touched;
    logic [3:0] waitCnt;
    logic [3:0] idx;
    logic [7:0] rdData;
    logic pushValid;
    logic [15:0] pushData;
    logic pushStatus;
    logic vecValid;
    logic [15:0] vecAddr;
    logic pcValid;
    logic [15:0] pcData;
  } mia_regs_t;

  localparam mia_regs_t REGS_RESET = '{
    state: ST_IDLE,
    reqFlags: REQ_RESET,
    maskFlags: MASK_RESET,
    status: STATUS_RESET,
    touched: 1'b0,
    waitCnt: 4'h0,
    idx: 4'h0,
    rdData: 8'h00,
    pushValid: 1'b0,
    pushData: 16'h0000,
    pushStatus: 1'b0,
    vecValid: 1'b0,
    vecAddr: 16'h0000,
    pcValid: 1'b0,
    pcData: 16'h0000
  };

  mia_regs_t r_q;
  mia_regs_t r_d;
  logic anyEligible;
  logic [3:0] pickIdx;
  logic flagRegHit;
  logic flagAccessNow;
  logic takeNow;
  logic [15:0] setMask;
  logic [15:0] clrMask;

  mia_prio_pick #(
    .N(NUM_SRC)
  ) u_pick (
    .reqFlags(r_q.reqFlags),
    .maskFlags(r_q.maskFlags),
    .anyEligible(anyEligible),
    .pickIdx(pickIdx)
  );

  // any port access that touches the request or mask flag registers
  assign flagRegHit = (regAddr == ADDR_REQ_LO) || (regAddr == ADDR_REQ_HI) ||
                      (regAddr == ADDR_MASK_LO) || (regAddr == ADDR_MASK_HI);
  assign flagAccessNow = instrFlagAccess || ((regWrStb || regRdStb) && flagRegHit);

  // decision at an instruction boundary; flags caught up to the clock before
  // the last are already registered, later ones wait a whole instruction
  assign takeNow = (r_q.state == ST_IDLE) && instrEnd && anyEligible
                   && r_q.status[STATUS_IE_BIT]
                   && !flagAccessNow
                   && !r_q.touched;

  // new requests from sources; set always beats any clear below
  assign setMask = srcReq & SRC_VALID;

  always_comb
  begin
    r_d = r_q;
    clrMask = 16'h0000;
    r_d.pushValid = 1'b0;
    r_d.pushStatus = 1'b0;
    r_d.vecValid = 1'b0;
    r_d.pcValid = 1'b0;

    // read data stands only in the cycle after the strobe
    r_d.rdData = 8'h00;
    if (regRdStb)
    begin
      case (regAddr)
        ADDR_REQ_LO: r_d.rdData = r_q.reqFlags[7:0];
        ADDR_REQ_HI: r_d.rdData = r_q.reqFlags[15:8];
        ADDR_MASK_LO: r_d.rdData = r_q.maskFlags[7:0];
        ADDR_MASK_HI: r_d.rdData = r_q.maskFlags[15:8];
        ADDR_STATUS: r_d.rdData = r_q.status;
        default: r_d.rdData = 8'h00;
      endcase
    end

    // software writes to flags and masks; reserved mask bits stay at one
    if (regWrStb)
    begin
      case (regAddr)
        ADDR_REQ_LO: r_d.reqFlags[7:0] = regWrData & SRC_VALID[7:0];
        ADDR_REQ_HI: r_d.reqFlags[15:8] = regWrData & SRC_VALID[15:8];
        ADDR_MASK_LO: r_d.maskFlags[7:0] = regWrData | ~SRC_VALID[7:0];
        ADDR_MASK_HI: r_d.maskFlags[15:8] = regWrData | ~SRC_VALID[15:8];
        ADDR_STATUS: r_d.status = regWrData;
        default: r_d = r_d;
      endcase
    end

    // enable and disable instructions, and status restored on return
    if (eiExec)
      r_d.status[STATUS_IE_BIT] = 1'b1;
    if (diExec)
      r_d.status[STATUS_IE_BIT] = 1'b0;
    if (retiExec)
      r_d.status = retiStatus;

    // an access anywhere in an instruction blocks that instruction's end;
    // the mark drops at the boundary so the very next end may take again
    if (instrEnd)
      r_d.touched = 1'b0;
    else if (flagAccessNow)
      r_d.touched = 1'b1;

    case (r_q.state)
      ST_IDLE:
      begin
        // untaken requests simply stay set and are retried each boundary
        if (takeNow)
        begin
          r_d.idx = pickIdx;
          r_d.state = ST_PUSH_STATUS;
        end
      end
      ST_PUSH_STATUS:
      begin
        // status is pushed and the enable drops in the same cycle so service is not nested
        r_d.pushValid = 1'b1;
        r_d.pushStatus = 1'b1;
        r_d.pushData = {8'h00, r_q.status};
        r_d.status[STATUS_IE_BIT] = 1'b0;
        clrMask[r_q.idx] = 1'b1;
        r_d.state = ST_PUSH_PC;
      end
      ST_PUSH_PC:
      begin
        r_d.pushValid = 1'b1;
        r_d.pushData = curPc;
        r_d.waitCnt = ACK_WAIT_CLKS;
        r_d.state = ST_WAIT;
      end
      ST_WAIT:
      begin
        // pads the sequence so the fastest path hits the minimum latency
        if (r_q.waitCnt <= 4'h1)
          r_d.state = ST_VEC_FETCH;
        else
          r_d.waitCnt = r_q.waitCnt - 4'h1;
      end
      ST_VEC_FETCH:
      begin
        r_d.vecValid = 1'b1;
        r_d.vecAddr = VEC_BASE + {11'h000, r_q.idx, 1'b0};
        r_d.state = ST_PC_LOAD;
      end
      ST_PC_LOAD:
      begin
        // memory answers in the same cycle that the fetch strobe stands
        r_d.pcValid = 1'b1;
        r_d.pcData = vecRdData;
        r_d.state = ST_IDLE;
      end
      default:
        r_d.state = ST_IDLE;
    endcase

    // set wins over both the ack clear and a software clear
    r_d.reqFlags = (r_d.reqFlags & ~clrMask) | setMask;
  end

  // all state in one register
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      r_q <= REGS_RESET;
    else
      r_q <= r_d;
  end

  // outputs straight from the register
  assign regRdData = r_q.rdData;
  assign ackBusy = (r_q.state != ST_IDLE);
  assign stackPushValid = r_q.pushValid;
  assign stackPushData = r_q.pushData;
  assign stackPushStatus = r_q.pushStatus;
  assign vecRdValid = r_q.vecValid;
  assign vecRdAddr = r_q.vecAddr;
  assign pcLoadValid = r_q.pcValid;
  assign pcLoadData = r_q.pcData;
  assign statusWord = r_q.status;
  assign ackSource = r_q.idx;
endmodule // mia_ack_ctrl

// [test/mia_ack_ctrl_props.sv]
`timescale 1ns/1ps
module mia_ack_ctrl_props
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic instrEnd,
  input wire logic instrFlagAccess,
  input wire logic ackBusy,
  input wire logic stackPushValid,
  input wire logic stackPushStatus,
  input wire logic vecRdValid,
  input wire logic [15:0] vecRdAddr,
  input wire logic pcLoadValid,
  input wire logic [7:0] statusWord,
  input wire logic [3:0] ackSource
);
  // one clock domain, so one clocking and one disable for all
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // acknowledge sequence order and timing
  property p_pc; stackPushStatus |=> stackPushValid && !stackPushStatus; endproperty
  a_pc: assert property (p_pc) else $error("pc push missing");
  property p_ie; stackPushStatus |-> !statusWord[7]; endproperty
  a_ie: assert property (p_ie) else $error("enable not cleared");
  property p_vec; stackPushStatus |-> ##5 vecRdValid; endproperty
  a_vec: assert property (p_vec) else $error("vector fetch late");
  property p_pcl; vecRdValid |-> ##1 pcLoadValid; endproperty
  a_pcl: assert property (p_pcl) else $error("no pc load");
  property p_vad; vecRdValid |-> vecRdAddr == {11'h000, ackSource, 1'b0}; endproperty
  a_vad: assert property (p_vad) else $error("wrong vector entry");
  // taking needs an instruction end with global enable set; the take cycle
  // lies two samples before the status push shows
  property p_take; stackPushStatus |-> $past(instrEnd, 2) && $past(statusWord[7], 2); endproperty
  a_take: assert property (p_take) else $error("taken off boundary");
  property p_nof; stackPushStatus |-> !$past(instrFlagAccess, 2); endproperty
  a_nof: assert property (p_nof) else $error("taken in flag access");
  property p_busy; stackPushStatus |-> ackBusy [*6]; endproperty
  a_busy: assert property (p_busy) else $error("busy dropped");
endmodule // mia_ack_ctrl_props

bind mia_ack_ctrl mia_ack_ctrl_props u_props (.*);

// [test/mia_cpu_model.sv]
`timescale 1ns/1ps
module mia_cpu_model
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic vecRdValid,
  input wire logic [15:0] vecRdAddr,
  output logic instrEnd,
  output logic [15:0] curPc,
  output logic [15:0] vecRdData
);
  logic [1:0] clkCnt_q;
  logic [15:0] noiseWord_q;
  // every instruction lasts four clocks
  assign instrEnd = (clkCnt_q == 2'h3);
  // table word while the fetch strobe stands, as the controller latches it
  // in that same cycle; a toggling pattern otherwise exposes a late sample
  assign vecRdData = vecRdValid ? (16'h1000 | vecRdAddr) : noiseWord_q;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clkCnt_q <= 2'h0;
      curPc <= 16'h0100;
      noiseWord_q <= 16'h0000;
    end
    else
    begin
      clkCnt_q <= clkCnt_q + 2'h1;
      curPc <= instrEnd ? curPc + 16'h0002 : curPc;
      noiseWord_q <= ~noiseWord_q;
    end
  end
endmodule // mia_cpu_model

// [test/maskable_interrupt_acknowledge_test.sv]
`timescale 1ns/1ps
module maskable_interrupt_acknowledge_test;
  import mia_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0, regRdStb = 1'b0, instrFlagAccess = 1'b0;
  logic eiExec = 1'b0, diExec = 1'b0, retiExec = 1'b0;
  logic [7:0] retiStatus = 8'h00;
  logic [NUM_SRC-1:0] srcReq = '0;
  logic [7:0] regRdData, statusWord;
  logic [15:0] curPc, vecRdData, stackPushData, vecRdAddr, pcLoadData;
  logic instrEnd, ackBusy, stackPushValid, stackPushStatus, vecRdValid, pcLoadValid;
  logic [3:0] ackSource;
  int errors = 0;
  int n_tests = 0;
  always #25 ref_clk = ~ref_clk;
  mia_ack_ctrl DUT (.*);
  mia_cpu_model cpu (.*);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 chk({8'h00, regRdData}, {8'h00, e});
  endtask
  // one-cycle source pulses plus enable, disable and return pulses
  task ctl(input logic [15:0] m, input logic [2:0] c, input logic [7:0] st);
    @(posedge ref_clk);
    srcReq <= m;
    {retiExec, diExec, eiExec} <= c;
    retiStatus <= st;
    @(posedge ref_clk);
    srcReq <= '0;
    {retiExec, diExec, eiExec} <= 3'b000;
  endtask
  // bounded wait for the pc load; n counts cycles since the request pulse
  task wack(input int src, input int lo, input int hi);
    int n;
    logic [15:0] pcSeen;
    // the pulse began one cycle before the call; outputs read once settled
    n = 1;
    pcSeen = 16'h0000;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
      if (stackPushStatus === 1'b1)
      begin
        chk(stackPushData, 16'h0082);
        pcSeen = curPc;
      end
      else if (stackPushValid === 1'b1)
        chk(stackPushData, pcSeen);
    end while (pcLoadValid !== 1'b1 && n < 60);
    chk({12'h000, ackSource}, 16'(src));
    chk(pcLoadData, 16'h1000 + 16'(2 * src));
    chk(16'(n >= lo && n <= hi), 16'h0001);
    if (pcLoadValid !== 1'b1)
      wrap_up();
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(ADDR_MASK_LO, 8'hFF);
    rd(ADDR_MASK_HI, 8'hFF);
    rd(ADDR_STATUS, 8'h02);
    rd(16'hFFF4, 8'h00);
    $display("test reset done");
    ctl(16'h0004, 3'b001, 8'h00);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_REQ_LO, 8'h04);
    wr(ADDR_MASK_LO, 8'h00);
    wr(ADDR_MASK_HI, 8'h00);
    wack(2, 0, 40);
    chk({8'h00, statusWord}, 16'h0002);
    rd(ADDR_REQ_LO, 8'h00);
    $display("test mask done");
    ctl(16'h001C, 3'b000, 8'h00);
    rd(ADDR_REQ_LO, 8'h1C);
    ctl(16'h0000, 3'b001, 8'h00);
    wack(2, 0, 40);
    ctl(16'h0000, 3'b001, 8'h00);
    wack(3, 0, 40);
    ctl(16'h0000, 3'b100, 8'h82);
    wack(4, 0, 40);
    $display("test priority done");
    ctl(16'h0008, 3'b001, 8'h00);
    wack(3, 9, 19);
    @(posedge ref_clk);
    instrFlagAccess <= 1'b1;
    ctl(16'h0010, 3'b001, 8'h00);
    repeat (12) @(posedge ref_clk);
    rd(ADDR_REQ_LO, 8'h10);
    @(posedge ref_clk);
    instrFlagAccess <= 1'b0;
    wack(4, 0, 40);
    ctl(16'h0000, 3'b001, 8'h00);
    ctl(16'h0008, 3'b010, 8'h00);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_REQ_LO, 8'h08);
    $display("test access done");
    // service code masks the lower source before it re-enables
    wr(ADDR_MASK_LO, 8'h10);
    ctl(16'h0010, 3'b001, 8'h00);
    wack(3, 0, 40);
    ctl(16'h0004, 3'b001, 8'h00);
    wack(2, 0, 40);
    rd(ADDR_REQ_LO, 8'h10);
    wr(ADDR_REQ_HI, 8'hFF);
    rd(ADDR_REQ_HI, 8'h7F);
    $display("test nesting done");
    wrap_up();
  end
endmodule // maskable_interrupt_acknowledge_test
